// *** dpsc_apd_timer.sv ***
// Automatic power-down timer
`default_nettype none
`include "dpsc_defs.svh"
module dpsc_apd_timer import dpsc_pkg::*; #(
	parameter int unsigned UNIT_CYCLES = `DPSC_APD_UNIT_CYC,
	parameter int unsigned CNT_W       = `DPSC_APD_CNT_W
) (
	input  wire logic clk,
	input  wire logic rst,
	dpsc_tmr_if.tmr   tif
);
	localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(UNIT_CYCLES - 1);

	logic [CNT_W-1:0]           tick;
	logic [`DPSC_APD_LIM_W-1:0] units;
	logic                       expired;
	logic [CNT_W-1:0]           next_tick;
	logic [`DPSC_APD_LIM_W-1:0] next_units;
	logic                       next_expired;

	// Restart whenever run drops; a zero limit never expires
	always_comb begin
		next_tick    = tick;
		next_units   = units;
		next_expired = expired;
		if (!tif.run) begin
			next_tick    = '0;
			next_units   = '0;
			next_expired = 1'b0;
		end else if (!expired) begin
			if (tick == TICK_LAST) begin
				next_tick  = '0;
				next_units = units + 1'b1;
				if (tif.limit != '0 && next_units == tif.limit) begin
					next_expired = 1'b1;
				end
			end else begin
				next_tick = tick + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick    <= '0;
			units   <= '0;
			expired <= 1'b0;
		end else begin
			tick    <= next_tick;
			units   <= next_units;
			expired <= next_expired;
		end
	end

	assign tif.expired = expired;

	// Expiry only ever follows a cycle in which the timer was running
	property p_exp_needs_run;
		@(posedge clk) disable iff (rst) expired |-> $past(tif.run);
	endproperty
	a_exp_needs_run: assert property (p_exp_needs_run)
		else $error("timer expired while not running");
endmodule // dpsc_apd_timer
`default_nettype wire

// *** dpsc_defs.svh ***
// Constants of the drive power-state controller
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH

// Power command and related opcodes
`define DPSC_OP_STBY_IMM   8'hE0
`define DPSC_OP_IDLE_IMM   8'hE1
`define DPSC_OP_STBY       8'hE2
`define DPSC_OP_IDLE       8'hE3
`define DPSC_OP_CHK_PWR    8'hE5
`define DPSC_OP_SLEEP      8'hE6
`define DPSC_OP_INIT_PARAM 8'h91

// Clock rate and power-down timer unit
`define DPSC_CLK_KHZ       125000
`define DPSC_APD_UNIT_MS   5000
`define DPSC_APD_UNIT_CYC  (`DPSC_APD_UNIT_MS * `DPSC_CLK_KHZ)
`define DPSC_APD_CNT_W     30
`define DPSC_APD_LIM_W     8

`endif

// *** dpsc_exec_model.sv ***
// Command executor and spindle stand-in for the power-state bench
`default_nettype none
module dpsc_exec_model #(
	parameter int DLY  = 3,
	parameter int SPIN = 5
) (
	input  wire logic clk,
	input  wire logic exec_start,
	input  wire logic spindle_on,
	output var  logic exec_done,
	output wire logic spin_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;

	// Finish each started command after a fixed work time
	always begin
		exec_done = 1'b0;
		@(posedge clk iff exec_start === 1'b1);
		repeat (DLY) @(negedge clk);
		exec_done = 1'b1;
		@(negedge clk);
	end

	// Spin-up takes time; at-speed is lost as soon as power is cut
	always @(negedge clk) begin
		if (spindle_on !== 1'b1)
			cnt = 0;
		else if (cnt < SPIN)
			cnt = cnt + 1;
	end
	assign spin_ready = (cnt == SPIN);
endmodule // dpsc_exec_model
`default_nettype wire

// *** dpsc_pkg.sv ***
// Types of the drive power-state controller
`default_nettype none
package dpsc_pkg;
	// Gray along active -> idle -> standby -> sleep
	typedef enum logic [1:0] {
		DPSC_ACTIVE  = 2'h0,
		DPSC_IDLE    = 2'h1,
		DPSC_STANDBY = 2'h3,
		DPSC_SLEEP   = 2'h2
	} dpsc_state_t;
endpackage
`default_nettype wire

// *** dpsc_power_ctl.sv ***
// Drive power-state controller: active, idle, standby and sleep
`default_nettype none
`include "dpsc_defs.svh"

module dpsc_power_ctl import dpsc_pkg::*; #(
	parameter int unsigned APD_UNIT_CYCLES = `DPSC_APD_UNIT_CYC
) (
	input  wire logic                       CLK,
	input  wire logic                       RST,
	input  wire logic                       RESET_PIN_N,
	input  wire logic                       SOFT_RESET,
	input  wire logic                       POWER_ON_DONE,
	input  wire logic                       CMD_VALID,
	input  wire logic [7:0]                 CMD_CODE,
	input  wire logic                       CMD_NEEDS_MEDIA,
	input  wire logic                       EXEC_DONE,
	input  wire logic                       SPIN_READY,
	input  wire logic                       APD_ENABLE,
	input  wire logic [`DPSC_APD_LIM_W-1:0] APD_LIMIT,
	output var  logic                       CMD_READY,
	output var  logic                       EXEC_START,
	output var  logic [7:0]                 EXEC_CODE,
	output var  logic                       CMD_REJECT,
	output var  logic                       PWR_CMD_DONE,
	output var  logic [1:0]                 POWER_STATE,
	output var  logic                       SPINDLE_ON,
	output var  logic                       ACTUATOR_ON,
	output var  logic                       CHECK_VALID,
	output var  logic [1:0]                 CHECK_STATE,
	output var  logic                       MEDIA_WAIT
);
	dpsc_tmr_if tmr_if ();

	// Reset pin synchroniser
	logic rpin_meta;
	logic rpin_sync_n;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rpin_meta   <= 1'b1;
			rpin_sync_n <= 1'b1;
		end else begin
			rpin_meta   <= RESET_PIN_N;
			rpin_sync_n <= rpin_meta;
		end
	end

	dpsc_state_t state;
	logic        busy;
	logic        por;
	logic        wait_media;
	logic        stay_sb;
	logic        ready;
	logic        exec_start;
	logic [7:0]  exec_code;
	logic        reject;
	logic        pc_done;
	logic        spindle;
	logic        chk_valid;
	logic [1:0]  chk_state;

	dpsc_state_t next_state;
	logic        next_busy;
	logic        next_por;
	logic        next_wait_media;
	logic        next_stay_sb;
	logic        next_ready;
	logic        next_exec_start;
	logic [7:0]  next_exec_code;
	logic        next_reject;
	logic        next_pc_done;
	logic        next_spindle;
	logic        next_chk_valid;
	logic [1:0]  next_chk_state;

	logic ata_rst;
	logic take;
	logic op_idle;
	logic op_stby;
	logic op_sleep;
	logic op_chk;
	logic is_power;

	// Interface reset from pin or host register, both level-held
	assign ata_rst  = !rpin_sync_n || SOFT_RESET;
	assign take     = CMD_VALID && ready;
	assign op_idle  = (CMD_CODE == `DPSC_OP_IDLE) || (CMD_CODE == `DPSC_OP_IDLE_IMM);
	assign op_stby  = (CMD_CODE == `DPSC_OP_STBY) || (CMD_CODE == `DPSC_OP_STBY_IMM);
	assign op_sleep = CMD_CODE == `DPSC_OP_SLEEP;
	assign op_chk   = CMD_CODE == `DPSC_OP_CHK_PWR;
	assign is_power = op_idle || op_stby || op_sleep || op_chk;

	// Timer only runs in settled idle; enable does not gate idle entry
	assign tmr_if.run   = (state == DPSC_IDLE) && !busy && APD_ENABLE;
	assign tmr_if.limit = APD_LIMIT;

	dpsc_apd_timer #(
		.UNIT_CYCLES (APD_UNIT_CYCLES),
		.CNT_W       (`DPSC_APD_CNT_W)
	) u_timer (
		.clk (CLK),
		.rst (RST),
		.tif (tmr_if.tmr)
	);

	// Power-state sequencing; reset beats everything else
	always_comb begin
		next_state      = state;
		next_busy       = busy;
		next_por        = por;
		next_wait_media = wait_media;
		next_stay_sb    = stay_sb;
		next_exec_code  = exec_code;
		next_chk_state  = chk_state;
		next_exec_start = 1'b0;
		next_reject     = 1'b0;
		next_pc_done    = 1'b0;
		next_chk_valid  = 1'b0;
		if (ata_rst) begin
			next_busy       = 1'b0;
			next_wait_media = 1'b0;
			next_stay_sb    = 1'b0;
			if (state == DPSC_SLEEP || state == DPSC_STANDBY) begin
				next_state = DPSC_STANDBY;
			end else if (!por) begin
				next_state = DPSC_IDLE;
			end
		end else if (por) begin
			next_state = DPSC_ACTIVE;
			if (POWER_ON_DONE) begin
				next_por   = 1'b0;
				next_state = DPSC_IDLE;
			end
		end else if (busy) begin
			if (wait_media) begin
				if (SPIN_READY) begin
					next_wait_media = 1'b0;
					next_exec_start = 1'b1;
				end
			end else if (EXEC_DONE) begin
				next_busy    = 1'b0;
				next_stay_sb = 1'b0;
				// Drop out of active on our own once work ends
				next_state   = stay_sb ? DPSC_STANDBY : DPSC_IDLE;
			end
		end else if (take) begin
			if (state == DPSC_SLEEP) begin
				next_reject = 1'b1;
			end else if (op_idle) begin
				next_state   = DPSC_IDLE;
				next_pc_done = 1'b1;
			end else if (op_stby) begin
				next_state   = DPSC_STANDBY;
				next_pc_done = 1'b1;
			end else if (op_sleep) begin
				next_state   = DPSC_SLEEP;
				next_pc_done = 1'b1;
			end else if (op_chk) begin
				next_chk_valid = 1'b1;
				next_chk_state = state;
				next_pc_done   = 1'b1;
			end else if (state == DPSC_STANDBY && CMD_CODE == `DPSC_OP_INIT_PARAM) begin
				next_busy       = 1'b1;
				next_stay_sb    = 1'b1;
				next_exec_start = 1'b1;
				next_exec_code  = CMD_CODE;
			end else begin
				next_state     = DPSC_ACTIVE;
				next_busy      = 1'b1;
				next_exec_code = CMD_CODE;
				// Spin-up first, so media commands just run late
				if (state == DPSC_STANDBY && CMD_NEEDS_MEDIA) begin
					next_wait_media = 1'b1;
				end else begin
					next_exec_start = 1'b1;
				end
			end
		end else if (state == DPSC_IDLE && tmr_if.expired) begin
			next_state = DPSC_STANDBY;
		end
		// Motor and actuator only outside standby and sleep
		next_spindle = (next_state == DPSC_ACTIVE) || (next_state == DPSC_IDLE);
		next_ready   = !next_busy && !next_por;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state      <= DPSC_ACTIVE;
			busy       <= 1'b0;
			por        <= 1'b1;
			wait_media <= 1'b0;
			stay_sb    <= 1'b0;
			ready      <= 1'b0;
			exec_start <= 1'b0;
			exec_code  <= 8'h00;
			reject     <= 1'b0;
			pc_done    <= 1'b0;
			spindle    <= 1'b1;
			chk_valid  <= 1'b0;
			chk_state  <= 2'h0;
		end else begin
			state      <= next_state;
			busy       <= next_busy;
			por        <= next_por;
			wait_media <= next_wait_media;
			stay_sb    <= next_stay_sb;
			ready      <= next_ready;
			exec_start <= next_exec_start;
			exec_code  <= next_exec_code;
			reject     <= next_reject;
			pc_done    <= next_pc_done;
			spindle    <= next_spindle;
			chk_valid  <= next_chk_valid;
			chk_state  <= next_chk_state;
		end
	end

	// Outputs straight from the flops
	assign CMD_READY    = ready;
	assign EXEC_START   = exec_start;
	assign EXEC_CODE    = exec_code;
	assign CMD_REJECT   = reject;
	assign PWR_CMD_DONE = pc_done;
	assign POWER_STATE  = state;
	assign SPINDLE_ON   = spindle;
	assign ACTUATOR_ON  = spindle;
	assign CHECK_VALID  = chk_valid;
	assign CHECK_STATE  = chk_state;
	assign MEDIA_WAIT   = wait_media;

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	property p_sleep_reject;
		take && state == DPSC_SLEEP && !ata_rst |=> CMD_REJECT && POWER_STATE == DPSC_SLEEP;
	endproperty
	a_sleep_reject: assert property (p_sleep_reject) else $error("sleep command not ignored");

	property p_sleep_exit;
		state == DPSC_SLEEP && ata_rst |=> POWER_STATE == DPSC_STANDBY;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) else $error("reset from sleep not standby");

	property p_sleep_entry;
		$changed(state) && state == DPSC_SLEEP |-> $past(take && op_sleep);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without command");

	property p_stby_cmd;
		take && op_stby && !ata_rst && (state == DPSC_ACTIVE || state == DPSC_IDLE)
		|=> POWER_STATE == DPSC_STANDBY && PWR_CMD_DONE && !SPINDLE_ON;
	endproperty
	a_stby_cmd: assert property (p_stby_cmd) else $error("standby command ignored");

	property p_stby_motor;
		POWER_STATE == DPSC_STANDBY || POWER_STATE == DPSC_SLEEP |-> !SPINDLE_ON && !ACTUATOR_ON;
	endproperty
	a_stby_motor: assert property (p_stby_motor) else $error("motor on in standby");

	property p_done_idle;
		busy && !wait_media && EXEC_DONE && !stay_sb && !ata_rst
		|=> POWER_STATE == DPSC_IDLE && CMD_READY;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("no idle after completion");

	property p_active_exec;
		take && !is_power && !ata_rst && state != DPSC_SLEEP && !stay_sb
		&& !(state == DPSC_STANDBY && CMD_CODE == `DPSC_OP_INIT_PARAM)
		|=> POWER_STATE == DPSC_ACTIVE && !CMD_READY;
	endproperty
	a_active_exec: assert property (p_active_exec) else $error("command not run in active");

	property p_check;
		take && op_chk && !ata_rst && state != DPSC_SLEEP
		|=> CHECK_VALID && CHECK_STATE == $past(POWER_STATE) && $stable(POWER_STATE);
	endproperty
	a_check: assert property (p_check) else $error("check power mode wrong");

	property p_media_wait;
		MEDIA_WAIT && !SPIN_READY && !ata_rst |=> !EXEC_START && SPINDLE_ON;
	endproperty
	a_media_wait: assert property (p_media_wait) else $error("media command ran before spin-up");

	property p_apd;
		state == DPSC_IDLE && !busy && tmr_if.expired && !take && !ata_rst
		|=> POWER_STATE == DPSC_STANDBY;
	endproperty
	a_apd: assert property (p_apd) else $error("timer expiry ignored");

	property p_por;
		por && POWER_ON_DONE && !ata_rst |=> POWER_STATE == DPSC_IDLE && CMD_READY;
	endproperty
	a_por: assert property (p_por) else $error("no idle after power-on");

	c_sleep_wake: cover property (state == DPSC_SLEEP && ata_rst ##1 state == DPSC_STANDBY);
	c_spin_up:    cover property (MEDIA_WAIT ##[1:20] EXEC_START);
	c_apd:        cover property (state == DPSC_IDLE ##1 state == DPSC_STANDBY);
	c_check:      cover property (CHECK_VALID && CHECK_STATE == DPSC_STANDBY);
endmodule // dpsc_power_ctl
`default_nettype wire

// *** dpsc_tmr_if.sv ***
// Link between the state controller and its power-down timer
`default_nettype none
`include "dpsc_defs.svh"
interface dpsc_tmr_if;
	logic                          run;
	logic [`DPSC_APD_LIM_W-1:0]    limit;
	logic                          expired;
	modport ctl (output run, output limit, input expired);
	modport tmr (input run, input limit, output expired);
endinterface
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench of the drive power-state controller
`default_nettype none
`include "dpsc_defs.svh"
module tb_top import dpsc_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       rpin_n = 1'b1;
	logic       srst = 1'b0;
	logic       pod = 1'b0;
	logic       cv = 1'b0;
	logic [7:0] code = 8'h00;
	logic       media = 1'b0;
	logic       apd_en = 1'b0;
	logic [7:0] apd_lim = 8'h00;
	logic       done, spin, rdy, xs, rej, pdone, spon, acon, cval, mwait;
	logic [7:0] xcode;
	logic [1:0] st, cst;
	int         mismatches = 0;
	int         num_checks = 0;
	int         cyc = 0;

	dpsc_power_ctl #(.APD_UNIT_CYCLES(4)) uut (
		.CLK(clk), .RST(rst), .RESET_PIN_N(rpin_n), .SOFT_RESET(srst),
		.POWER_ON_DONE(pod), .CMD_VALID(cv), .CMD_CODE(code),
		.CMD_NEEDS_MEDIA(media), .EXEC_DONE(done), .SPIN_READY(spin),
		.APD_ENABLE(apd_en), .APD_LIMIT(apd_lim), .CMD_READY(rdy),
		.EXEC_START(xs), .EXEC_CODE(xcode), .CMD_REJECT(rej),
		.PWR_CMD_DONE(pdone), .POWER_STATE(st), .SPINDLE_ON(spon),
		.ACTUATOR_ON(acon), .CHECK_VALID(cval), .CHECK_STATE(cst),
		.MEDIA_WAIT(mwait));
	dpsc_exec_model exe (.clk(clk), .exec_start(xs), .spindle_on(spon),
		.exec_done(done), .spin_ready(spin));

	// 125 MHz clock
	initial forever #4 clk = ~clk;

	// Hang guard well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic close_out();
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// Offer one command at a falling edge; returns with the answer cycle visible
	task automatic send(input logic [7:0] c, input logic m);
		// Let an edge pass with valid low, so back-to-back calls never rewrite it in one step
		@(negedge clk);
		for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge clk);
		cv = 1'b1;
		code = c;
		media = m;
		@(negedge clk);
		cv = 1'b0;
		media = 1'b0;
	endtask

	task automatic wait_st(input dpsc_state_t e, input int n);
		for (int i = 0; i < n && st !== e; i++) @(negedge clk);
		chk(8'(st), 8'(e));
	endtask

	task automatic t_power_on();
		chk(8'(st), 8'(DPSC_ACTIVE));
		@(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk(8'(rdy), 8'h00);
		pod = 1'b1;
		repeat (2) @(negedge clk);
		chk(8'(st), 8'(DPSC_IDLE));
		chk(8'(spon), 8'h01);
	endtask

	// Ordinary command: active, then back to idle whether power-down is on or off
	task automatic t_exec(input logic en);
		apd_en = en;
		send(8'h20, 1'b0);
		chk(8'(st), 8'(DPSC_ACTIVE));
		chk(8'(xs), 8'h01);
		chk(xcode, 8'h20);
		wait_st(DPSC_IDLE, 10);
		chk(8'(st), 8'(DPSC_IDLE));
		chk({6'h00, spon, acon}, 8'h03);
	endtask

	task automatic t_power_cmds();
		send(`DPSC_OP_STBY_IMM, 1'b0);
		chk(8'(st), 8'(DPSC_STANDBY));
		chk(8'(pdone), 8'h01);
		chk({6'h00, spon, acon}, 8'h00);
		send(`DPSC_OP_CHK_PWR, 1'b0);
		chk(8'(cval), 8'h01);
		chk(8'(cst), 8'(DPSC_STANDBY));
		chk(8'(st), 8'(DPSC_STANDBY));
		send(`DPSC_OP_STBY, 1'b0);
		chk(8'(st), 8'(DPSC_STANDBY));
		send(`DPSC_OP_INIT_PARAM, 1'b0);
		chk(8'(xs), 8'h01);
		chk(8'(st), 8'(DPSC_STANDBY));
		repeat (8) @(negedge clk);
		chk(8'(st), 8'(DPSC_STANDBY));
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk(8'(st), 8'(DPSC_STANDBY));
		send(`DPSC_OP_IDLE_IMM, 1'b0);
		chk(8'(st), 8'(DPSC_IDLE));
		send(`DPSC_OP_STBY, 1'b0);
		chk(8'(st), 8'(DPSC_STANDBY));
		send(`DPSC_OP_IDLE, 1'b0);
		chk(8'(st), 8'(DPSC_IDLE));
		send(`DPSC_OP_CHK_PWR, 1'b0);
		chk(8'(cst), 8'(DPSC_IDLE));
	endtask

	// Disk access from standby has to wait for spin-up
	task automatic t_media();
		send(`DPSC_OP_STBY_IMM, 1'b0);
		send(8'h20, 1'b1);
		chk(8'(st), 8'(DPSC_ACTIVE));
		chk({6'h00, mwait, xs}, 8'h02);
		for (int i = 0; i < 20 && xs !== 1'b1; i++) @(negedge clk);
		chk({6'h00, mwait, xs}, 8'h01);
		wait_st(DPSC_IDLE, 10);
	endtask

	// Sleep ignores commands; only a reset leaves it, and into standby
	task automatic t_sleep(input logic hw);
		send(`DPSC_OP_SLEEP, 1'b0);
		chk(8'(st), 8'(DPSC_SLEEP));
		send(8'h20, 1'b0);
		chk({6'h00, rej, xs}, 8'h02);
		send(`DPSC_OP_IDLE, 1'b0);
		chk(8'(rej), 8'h01);
		chk(8'(st), 8'(DPSC_SLEEP));
		// Pin or host register: leave sleep through a reset only
		if (hw)
			rpin_n = 1'b0;
		else
			srst = 1'b1;
		repeat (3) @(negedge clk);
		{rpin_n, srst} = 2'b10;
		// The pin release needs two more edges through the synchroniser
		repeat (2) @(negedge clk);
		chk(8'(st), 8'(DPSC_STANDBY));
	endtask

	// Power-down timer: two units of four cycles from idle
	task automatic t_apd();
		send(`DPSC_OP_IDLE, 1'b0);
		apd_lim = 8'h02;
		apd_en = 1'b1;
		repeat (5) @(negedge clk);
		chk(8'(st), 8'(DPSC_IDLE));
		wait_st(DPSC_STANDBY, 8);
	endtask

	initial begin
		repeat (19) @(negedge clk);
		t_power_on();
		t_exec(1'b0);
		t_exec(1'b1);
		t_power_cmds();
		t_media();
		t_sleep(1'b1);
		t_sleep(1'b0);
		t_apd();
		close_out();
	end
endmodule // tb_top
`default_nettype wire
